// ==== rtl/emergency_drive_params.svh ====
// Constants for the emergency drive mode controller
`ifndef EMERGENCY_DRIVE_PARAMS_SVH
`define EMERGENCY_DRIVE_PARAMS_SVH
`define MON_SEL_STATUS_CODE   8'h44
`define STAT_UNSET            8'h00
`define STAT_BYPASS_BASE      8'h0A
`define STAT_NORMAL_DIGIT     4'h1
`define STAT_PROPER_DIGIT     4'h2
`define STAT_ALARM_DIGIT      4'h3
`define STAT_RETRY_DIGIT      4'h4
`define STAT_SHUTOFF_DIGIT    4'h5
`define TENS_RAMP             4'h2
`define TENS_INTERLOCK        4'h3
`define TENS_MAINS            4'h4
`define TENS_WEIGHT           8'h0A
`define RESTART_SEL_CONVERTER 2'h2
`endif

// ==== rtl/emergency_drive_pkg.sv ====
// Types for the emergency drive mode controller
package emergency_drive_pkg;
    typedef enum logic [1:0] { MODE_FIXED, MODE_LOOP } drive_mode_e;
    typedef struct packed {
        logic second_function_select_input;
        logic vf_switchover_input;
        logic contactor_input;
        logic sequence_start_input;
        logic emergency_drive_request_input;
        logic loop_direction_input;
        logic pump_stop_input_a;
        logic pump_stop_input_b;
        logic pump_stop_input_c;
        logic loop_enable_input;
    } held_inputs_s;
    typedef struct packed {
        logic external_overheat_input;
        logic trace_trigger_input;
        logic trace_sampling_input;
        logic sequence_fault_clear_input;
        logic device_reset_input;
    } valid_inputs_s;
    typedef struct packed {
        logic param_write;
        logic param_clear;
        logic all_param_clear;
        logic param_copy;
    } param_req_s;
endpackage

// ==== rtl/emergency_drive_mode_control.sv ====
// Emergency drive mode, input gating, status monitor and bypass control
// Summary of operation
// - Ignore unrelated inputs during emergency drive
// - Overheat, trace, fault clear, reset stay live
// - Fixed mode holds select, contactor, sequence, request
// - Loop mode also holds direction, pumps; enable on
// - Status shown on monitor slot coded 68
// - Codes 0 to 5 without bypass
// - Codes 11 to 15 with bypass
// - Bypass tens 2,3,4; ones keep previous
// - Reject parameter changes while active
// - Reset, fault clear or a disabling condition ends drive
// - Sequence fault clear ends drive on trip
// - Keep in-operation status after fault clear
// - Bypass switches to mains on power failure
// - Mains contactor stays off on undervoltage
// - Disabled by restart select 2 with converter
// - Disabled by vector control, tuning, brake
// - Active output high throughout emergency drive
`include "emergency_drive_params.svh"
module emergency_drive_mode_control #(
    parameter int MON_SLOTS = 5
) (
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire logic                               function_enabled,
    input  wire logic                               bypass_enabled,
    input  wire logic                               loop_mode_select,
    input  wire logic [1:0]                         power_failure_restart_select,
    input  wire logic                               converter_in_use,
    input  wire logic                               vector_control,
    input  wire logic                               auto_tuning,
    input  wire logic                               brake_sequence_enabled,
    input  wire logic                               sequence_function_enabled,
    input  wire logic                               protective_tripped,
    input  wire logic                               alarm_present,
    input  wire logic                               fault_retry,
    input  wire logic                               fault_shutoff,
    input  wire logic                               power_failure,
    input  wire logic                               undervoltage_trip,
    input  wire logic                               bypass_at_switch_freq,
    input  wire logic                               interlock_done,
    input  wire logic [MON_SLOTS*8-1:0]             panel_monitor_select,
    input  wire emergency_drive_pkg::held_inputs_s  held_in,
    input  wire emergency_drive_pkg::valid_inputs_s valid_in,
    input  wire logic                               other_inputs_in,
    input  wire emergency_drive_pkg::param_req_s    param_req,
    output logic                                    emergency_active_output,
    output logic                                    mains_side_contactor_output,
    output logic                                    mains_operation,
    output logic [7:0]                              status_code,
    output logic [MON_SLOTS-1:0]                    monitor_shows_status,
    output emergency_drive_pkg::held_inputs_s       held_out,
    output emergency_drive_pkg::valid_inputs_s      valid_out,
    output logic                                    other_inputs_out,
    output emergency_drive_pkg::param_req_s         param_grant
);

    // Bypass steps: ramp to switchover frequency, interlock wait, then mains
    typedef enum logic [1:0] { BP_NONE, BP_RAMP, BP_INTERLOCK, BP_MAINS } bypass_state_e;

    // Drive state, latched terminals and the next-state terms
    emergency_drive_pkg::drive_mode_e  mode_reg;
    emergency_drive_pkg::held_inputs_s latch_reg;
    bypass_state_e                     bp_reg;
    bypass_state_e                     bp_next;
    logic                              active_reg;
    logic                              in_op_reg;
    logic                              uv_seen_reg;
    logic [3:0]                        ones_reg;
    logic [3:0]                        ones_next;
    logic [7:0]                        status_next;
    logic                              allowed;
    logic                              start;
    logic                              fault_exit;

    // Status value from a tens and a ones digit, shared by every bypass step
    function automatic logic [7:0] code_of(input logic [3:0] tens, input logic [3:0] ones);
        code_of = 8'(tens * `TENS_WEIGHT) + {4'h0, ones};
    endfunction

    // Function off when any forbidding condition holds
    assign allowed = function_enabled
                   && !(power_failure_restart_select == `RESTART_SEL_CONVERTER && converter_in_use)
                   && !vector_control && !auto_tuning && !brake_sequence_enabled;
    assign start      = allowed && !active_reg && held_in.emergency_drive_request_input;
    assign fault_exit = sequence_function_enabled && protective_tripped
                      && valid_in.sequence_fault_clear_input;

    // Active flag: request level alone never clears it; reset, fault clear or a disabling condition does
    always_ff @(posedge ref_clk) begin
        if (rst || valid_in.device_reset_input) begin
            active_reg <= 1'b0;
        end else if (active_reg && (fault_exit || !allowed)) begin
            active_reg <= 1'b0;
        end else if (start) begin
            active_reg <= 1'b1;
        end
    end

    // Mode chosen at entry and kept for the whole drive
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= emergency_drive_pkg::MODE_FIXED;
        end else if (start) begin
            mode_reg <= loop_mode_select ? emergency_drive_pkg::MODE_LOOP : emergency_drive_pkg::MODE_FIXED;
        end
    end

    // Latch held inputs on entry; a fault clear exit keeps the reported status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            latch_reg <= '0;
        end else if (start) begin
            latch_reg <= held_in;
        end
    end

    // In-operation memory outlives a fault clear exit; only a reset drops it,
    // so the panel keeps warning that the drive has run in emergency mode
    always_ff @(posedge ref_clk) begin
        if (rst || valid_in.device_reset_input) begin
            in_op_reg <= 1'b0;
        end else if (start) begin
            in_op_reg <= 1'b1;
        end
    end

    // Bypass sequencing toward mains operation
    always_comb begin
        bp_next = bp_reg;
        case (bp_reg)
            BP_NONE: begin
                if (active_reg && bypass_enabled && (power_failure || undervoltage_trip)) begin
                    bp_next = BP_RAMP;
                end
            end
            BP_RAMP: begin
                if (bypass_at_switch_freq) begin
                    bp_next = BP_INTERLOCK;
                end
            end
            BP_INTERLOCK: begin
                if (interlock_done) begin
                    bp_next = BP_MAINS;
                end
            end
            BP_MAINS: bp_next = BP_MAINS;
            default:  bp_next = BP_NONE;
        endcase
        // Leaving the drive abandons any bypass in progress
        if (!active_reg) begin
            bp_next = BP_NONE;
        end
    end

    // Bypass step register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bp_reg <= BP_NONE;
        end else begin
            bp_reg <= bp_next;
        end
    end

    // Undervoltage remembered so the mains contactor stays open
    always_ff @(posedge ref_clk) begin
        if (rst || !active_reg) begin
            uv_seen_reg <= 1'b0;
        end else if (undervoltage_trip) begin
            uv_seen_reg <= 1'b1;
        end
    end

    // Mains flags taken from the next step so they move with the status code;
    // the live trip term covers the cycle before the memory above is set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mains_operation             <= 1'b0;
            mains_side_contactor_output <= 1'b0;
        end else begin
            mains_operation             <= (bp_next == BP_MAINS);
            mains_side_contactor_output <= (bp_next == BP_MAINS) && !uv_seen_reg && !undervoltage_trip;
        end
    end

    // Ones digit of the status, frozen once bypass begins
    // Shutoff outranks retry, which outranks a plain alarm
    always_comb begin
        ones_next = `STAT_NORMAL_DIGIT;
        if (in_op_reg || active_reg) begin
            if (fault_shutoff) begin
                ones_next = `STAT_SHUTOFF_DIGIT;
            end else if (fault_retry) begin
                ones_next = `STAT_RETRY_DIGIT;
            end else if (alarm_present) begin
                ones_next = `STAT_ALARM_DIGIT;
            end else begin
                ones_next = `STAT_PROPER_DIGIT;
            end
        end
        if (bp_reg != BP_NONE) begin
            ones_next = ones_reg;
        end
    end

    // Ones digit register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ones_reg <= `STAT_NORMAL_DIGIT;
        end else begin
            ones_reg <= ones_next;
        end
    end

    // Full status code
    // Plain digit without bypass, base or tens digit added with it
    always_comb begin
        if (!function_enabled) begin
            status_next = `STAT_UNSET;
        end else if (!bypass_enabled) begin
            status_next = {4'h0, ones_next};
        end else begin
            case (bp_next)
                BP_RAMP:      status_next = code_of(`TENS_RAMP, ones_next);
                BP_INTERLOCK: status_next = code_of(`TENS_INTERLOCK, ones_next);
                BP_MAINS:     status_next = code_of(`TENS_MAINS, ones_next);
                default:      status_next = `STAT_BYPASS_BASE + {4'h0, ones_next};
            endcase
        end
    end

    // Status register; the value is binary and the panel shows it in decimal,
    // so a bypass code such as 23 leaves here as 8'h17
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_code <= `STAT_UNSET;
        end else begin
            status_code <= status_next;
        end
    end

    // Monitor slots that select the status code
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            monitor_shows_status <= '0;
        end else begin
            for (int i = 0; i < MON_SLOTS; i++) begin
                monitor_shows_status[i] <= (panel_monitor_select[i*8 +: 8] == `MON_SEL_STATUS_CODE);
            end
        end
    end

    // Input gating seen by the rest of the drive
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            held_out         <= '0;
            valid_out        <= '0;
            other_inputs_out <= 1'b0;
        end else begin
            valid_out        <= valid_in;
            other_inputs_out <= active_reg ? 1'b0 : other_inputs_in;
            held_out         <= held_in;
            // Latched levels replace the live ones only while the drive runs
            if (active_reg) begin
                held_out.second_function_select_input  <= latch_reg.second_function_select_input;
                held_out.vf_switchover_input           <= latch_reg.vf_switchover_input;
                held_out.contactor_input               <= latch_reg.contactor_input;
                held_out.sequence_start_input          <= latch_reg.sequence_start_input;
                held_out.emergency_drive_request_input <= latch_reg.emergency_drive_request_input;
                if (mode_reg == emergency_drive_pkg::MODE_LOOP) begin
                    held_out.loop_direction_input <= latch_reg.loop_direction_input;
                    held_out.pump_stop_input_a    <= latch_reg.pump_stop_input_a;
                    held_out.pump_stop_input_b    <= latch_reg.pump_stop_input_b;
                    held_out.pump_stop_input_c    <= latch_reg.pump_stop_input_c;
                    held_out.loop_enable_input    <= 1'b1;
                end else begin
                    held_out.loop_direction_input <= 1'b0;
                    held_out.pump_stop_input_a    <= 1'b0;
                    held_out.pump_stop_input_b    <= 1'b0;
                    held_out.pump_stop_input_c    <= 1'b0;
                    held_out.loop_enable_input    <= 1'b0;
                end
            end
        end
    end

    // Parameter requests blocked while active; active output follows drive state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            param_grant             <= '0;
            emergency_active_output <= 1'b0;
        end else begin
            param_grant             <= active_reg ? '0 : param_req;
            emergency_active_output <= active_reg;
        end
    end

endmodule // emergency_drive_mode_control

// ==== sim/emergency_drive_sva.sv ====
// Property checker for the emergency drive mode controller
`include "emergency_drive_params.svh"
module emergency_drive_sva #(
    parameter int MON_SLOTS = 5
) (
    input wire logic                               ref_clk,
    input wire logic                               rst,
    input wire logic                               function_enabled,
    input wire logic [1:0]                         power_failure_restart_select,
    input wire logic                               converter_in_use,
    input wire logic                               vector_control,
    input wire logic                               auto_tuning,
    input wire logic                               brake_sequence_enabled,
    input wire logic                               sequence_function_enabled,
    input wire logic                               protective_tripped,
    input wire logic                               undervoltage_trip,
    input wire logic [MON_SLOTS*8-1:0]             panel_monitor_select,
    input wire emergency_drive_pkg::held_inputs_s  held_in,
    input wire emergency_drive_pkg::valid_inputs_s valid_in,
    input wire logic                               other_inputs_in,
    input wire emergency_drive_pkg::param_req_s    param_req,
    input wire logic                               emergency_active_output,
    input wire logic                               mains_side_contactor_output,
    input wire logic [7:0]                         status_code,
    input wire logic [MON_SLOTS-1:0]               monitor_shows_status,
    input wire emergency_drive_pkg::valid_inputs_s valid_out,
    input wire logic                               other_inputs_out,
    input wire emergency_drive_pkg::param_req_s    param_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic up_reg;
    logic bar;
    logic quit;
    logic clr;
    // Past values are trusted only after one clean edge out of reset
    always_ff @(posedge ref_clk) up_reg <= !rst;
    // Any disabling condition, and anything that ends the drive
    assign bar = vector_control | auto_tuning | brake_sequence_enabled | !function_enabled
                 | (converter_in_use && power_failure_restart_select == `RESTART_SEL_CONVERTER);
    assign clr = sequence_function_enabled & protective_tripped & valid_in.sequence_fault_clear_input;
    assign quit = bar | valid_in.device_reset_input | clr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_ask;
        !quit && held_in.emergency_drive_request_input;
    endsequence
    sequence s_quiet;
        !held_in.emergency_drive_request_input [*2];
    endsequence
    property p_exit(c);
        c ##1 s_quiet |-> ##[0:1] !emergency_active_output;
    endproperty
    AST_ENTRY: assert property (s_ask |-> ##2 emergency_active_output)
        else $error("drive did not start on request");
    AST_STAY: assert property (emergency_active_output && !$past(quit) |=> emergency_active_output)
        else $error("drive ended without cause");
    AST_CAUSE: assert property ($rose(emergency_active_output) |-> $past(held_in.emergency_drive_request_input, 2))
        else $error("drive started without request");
    AST_RESET_EXIT: assert property (p_exit(valid_in.device_reset_input))
        else $error("device reset did not end drive");
    AST_FAULT_EXIT: assert property (p_exit(clr))
        else $error("fault clear did not end drive");
    AST_BARRED: assert property (p_exit(bar))
        else $error("drive active while disabled");
    AST_OTHER: assert property (up_reg |-> other_inputs_out == ($past(other_inputs_in) && !emergency_active_output))
        else $error("unrelated input not gated");
    AST_GRANT: assert property (up_reg |-> param_grant == ($past(param_req) & {4{!emergency_active_output}}))
        else $error("parameter request gating wrong");
    AST_VALID: assert property (up_reg |-> valid_out == $past(valid_in))
        else $error("valid input not passed");
    AST_UV_CONTACTOR: assert property (undervoltage_trip |=> !mains_side_contactor_output [*3])
        else $error("mains contactor on after undervoltage");
    AST_UNSET: assert property (!function_enabled |=> status_code == `STAT_UNSET)
        else $error("status not zero when unset");
    for (genvar i = 0; i < MON_SLOTS; i++) begin : g_mon
        AST_MONITOR: assert property (up_reg |-> monitor_shows_status[i] == ($past(panel_monitor_select[i*8 +: 8]) == `MON_SEL_STATUS_CODE))
            else $error("monitor slot flag wrong");
    end
endmodule // emergency_drive_sva

bind emergency_drive_mode_control emergency_drive_sva #(.MON_SLOTS(MON_SLOTS)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .function_enabled(function_enabled),
    .power_failure_restart_select(power_failure_restart_select), .converter_in_use(converter_in_use),
    .vector_control(vector_control), .auto_tuning(auto_tuning), .brake_sequence_enabled(brake_sequence_enabled),
    .sequence_function_enabled(sequence_function_enabled), .protective_tripped(protective_tripped),
    .undervoltage_trip(undervoltage_trip), .panel_monitor_select(panel_monitor_select), .held_in(held_in),
    .valid_in(valid_in), .other_inputs_in(other_inputs_in), .param_req(param_req),
    .emergency_active_output(emergency_active_output), .mains_side_contactor_output(mains_side_contactor_output),
    .status_code(status_code), .monitor_shows_status(monitor_shows_status), .valid_out(valid_out),
    .other_inputs_out(other_inputs_out), .param_grant(param_grant));

// ==== sim/terminal_model.sv ====
// Terminal block stand-in that drives the raw terminal inputs
module terminal_model (
    input  wire logic                               ref_clk,
    input  wire logic                               request,
    input  wire logic [31:0]                        noise,
    output emergency_drive_pkg::held_inputs_s       held_in,
    output logic                                    other_inputs_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] bits_reg = 10'h000;
    // Terminals move only after the falling edge, clear of sampling
    always @(negedge ref_clk) bits_reg <= noise[9:0];
    // Request is the controller's own line, kept combinational to avoid races
    assign held_in = {bits_reg[9:6], request, bits_reg[4:0]};
    assign other_inputs_in = bits_reg[3] ^ bits_reg[7];
endmodule // terminal_model

// ==== sim/emergency_drive_mode_control_tb.sv ====
// Self-checking bench for the emergency drive mode controller
module emergency_drive_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic fe, byp, loop, conv, vec, tune, brake, seqf, trip, alarm, retry, shut, pf, uv, atf, ild;
    } ctl_s;
    typedef struct { int kind; logic [9:0] exp; } note_s;
    note_s                              notes[$];
    note_s                              n;
    ctl_s                               c;
    logic                               ref_clk, rst, req, dres, fclr;
    logic [1:0]                         rsel;
    logic [31:0]                        r = 32'hF6B80275;
    logic [39:0]                        pms;
    logic [2:0]                         vr;
    emergency_drive_pkg::held_inputs_s  hin, hout, lat;
    emergency_drive_pkg::valid_inputs_s vin, vout;
    emergency_drive_pkg::param_req_s    preq, pgr;
    logic                               oin, oout, act, mc, mains;
    logic [7:0]                         stat;
    logic [4:0]                         mon;
    int                                 fail_count = 0;
    int                                 checked = 0;
    assign vin = {vr, fclr, dres};
    emergency_drive_mode_control #(.MON_SLOTS(5)) dut (.ref_clk(ref_clk), .rst(rst), .function_enabled(c.fe),
        .bypass_enabled(c.byp), .loop_mode_select(c.loop), .power_failure_restart_select(rsel),
        .converter_in_use(c.conv), .vector_control(c.vec), .auto_tuning(c.tune), .brake_sequence_enabled(c.brake),
        .sequence_function_enabled(c.seqf), .protective_tripped(c.trip), .alarm_present(c.alarm),
        .fault_retry(c.retry), .fault_shutoff(c.shut), .power_failure(c.pf), .undervoltage_trip(c.uv),
        .bypass_at_switch_freq(c.atf), .interlock_done(c.ild), .panel_monitor_select(pms), .held_in(hin),
        .valid_in(vin), .other_inputs_in(oin), .param_req(preq), .emergency_active_output(act),
        .mains_side_contactor_output(mc), .mains_operation(mains), .status_code(stat),
        .monitor_shows_status(mon), .held_out(hout), .valid_out(vout), .other_inputs_out(oout), .param_grant(pgr));
    terminal_model u_term (.ref_clk(ref_clk), .request(req), .noise(r), .held_in(hin), .other_inputs_in(oin));
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task step(int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task note(int k, logic [9:0] e);
        notes.push_back('{k, e});
    endtask
    task cmp_status(logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t status got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_flags(logic [9:0] got, logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flags got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Random noise on every terminal the bench does not steer
    always @(negedge ref_clk) begin
        r = lfsr(r);
        vr <= r[13:11];
        preq <= r[19:16];
        pms <= {r[31:16], 8'h44, r[15:0]};
    end
    // Outputs read before the edge's own updates land
    always @(posedge ref_clk) while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.kind)
            1: cmp_status(stat, n.exp[7:0]);
            0: cmp_flags({9'h000, act}, n.exp);
            2: cmp_flags(hout, n.exp);
            3: cmp_flags({6'h00, pgr}, n.exp);
            4: cmp_flags({9'h000, oout}, n.exp);
            7: cmp_flags({9'h000, mains}, n.exp);
            default: cmp_flags({9'h000, mc}, n.exp);
        endcase
    end
    // Whole run is under a hundred cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        c = '0; rst = 1'b1; req = 1'b0; dres = 1'b0; fclr = 1'b0; rsel = 2'h0;
        step(3);
        rst = 1'b0;
        step(2);
        note(1, 10'h000);
        c.fe = 1'b1;
        step(2);
        note(1, 10'h001);
        for (int i = 0; i < 4; i++) begin
            c.vec = i == 0; c.tune = i == 1; c.brake = i == 2; c.conv = i == 3; rsel = (i == 3) ? 2'h2 : 2'h0;
            req = 1'b1;
            step(4);
            note(0, 10'h000);
        end
        c.conv = 1'b0; rsel = 2'h0; req = 1'b0;
        step(1);
        req = 1'b1;
        @(posedge ref_clk) lat = hin;
        step(3);
        req = 1'b0;
        note(0, 10'h001);
        note(2, {lat[9:5], 5'h00});
        note(3, 10'h000);
        note(4, 10'h000);
        note(1, 10'h002);
        for (int i = 0; i < 3; i++) begin
            c.alarm = 1'b1; c.retry = i > 0; c.shut = i > 1;
            step(2);
            note(1, 10'(3 + i));
        end
        c.alarm = 1'b0; c.retry = 1'b0; c.shut = 1'b0;
        step(3);
        note(0, 10'h001);
        dres = 1'b1;
        step(1);
        dres = 1'b0;
        step(3);
        note(0, 10'h000);
        note(1, 10'h001);
        for (int k = 0; k < 2; k++) begin
            c.byp = 1'b1; c.loop = 1'b1; req = 1'b1;
            @(posedge ref_clk) lat = hin;
            step(3);
            req = 1'b0;
            note(2, {lat[9:1], 1'b1});
            note(1, 10'h00C);
            c.alarm = 1'b1;
            step(2);
            note(1, 10'h00D);
            c.pf = k == 0; c.uv = k == 1;
            step(1);
            c.alarm = 1'b0;
            step(2);
            note(1, 10'h017);
            c.atf = 1'b1;
            step(3);
            note(1, 10'h021);
            c.ild = 1'b1;
            step(3);
            note(1, 10'h02B);
            note(7, 10'h001);
            note(8, 10'(k == 0));
            rst = 1'b1; c = '0; c.fe = 1'b1;
            step(1);
            rst = 1'b0;
        end
        req = 1'b1;
        step(3);
        req = 1'b0; c.seqf = 1'b1; c.trip = 1'b1; fclr = 1'b1;
        step(1);
        fclr = 1'b0;
        step(3);
        note(0, 10'h000);
        note(1, 10'h002);
        req = 1'b1;
        step(3);
        note(0, 10'h001);
        req = 1'b0; c.tune = 1'b1;
        step(3);
        note(0, 10'h000);
        step(2);
        end_of_test();
    end
endmodule // emergency_drive_mode_control_tb
